/* File: rtl/wkeg_gate.sv */
// Purpose: latches wake status and forms the gated wake request
// Assumes: evt already synchronised; i_reset is the standby power-on reset
// Notes: only standby reset touches status
`timescale 1ns/1ps
module wkeg_gate (
  // clock and standby reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // vectors
  wkeg_gate_if.gate g
);
  import wkeg_pkg::*;
  logic [SRC_W-1:0] sts_ff;

  // set beats a same-cycle clear so no event is lost
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sts_ff <= STS_RST;
    end else begin
      sts_ff <= ((sts_ff & ~g.clr) | g.evt) & SRC_VALID; // [R8] [R9]
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < GRP_N; gi++) begin : grp
      assign g.new_set[gi] = |(g.evt[gi*8 +: 8] & ~sts_ff[gi*8 +: 8] & SRC_VALID[gi*8 +: 8]);
    end
  endgenerate

  assign g.sts = sts_ff;
  // enable only gates the pin, never the latch
  assign g.wake = g.glob_en & (|(sts_ff & g.en)); // [R1] [R2] [R10]
endmodule

/* File: rtl/wkeg_gate_if.sv */
// Purpose: carries source, enable and status vectors to the gating unit
// Assumes: single clock domain
// Notes: clr is a one-cycle pulse per bit
`timescale 1ns/1ps
interface wkeg_gate_if;
  import wkeg_pkg::*;
  logic [SRC_W-1:0] evt;
  logic [SRC_W-1:0] en;
  logic [SRC_W-1:0] clr;
  logic [SRC_W-1:0] sts;
  logic [GRP_N-1:0] new_set;
  logic glob_en;
  logic wake;
  modport gate (input evt, en, clr, glob_en, output sts, new_set, wake);
  modport ctl (output evt, en, clr, glob_en, input sts, new_set, wake);
endinterface

/* File: rtl/wkeg_pkg.sv */
// Purpose: constants for wake event enable gating
// Assumes: registers sit one per 32-bit word, byte address = index * 4
// Notes: source vector is gp1x [7:0], peripherals [15:8], gp2x [23:16]
//
// Summary of operation
// R1: enabled, latched source with global enable asserts wake
// R2: disabled source still latches, never drives wake
// R3: enables survive main, soft, hard resets
// R4: index 0C bits 3:0 gate gp20..23
// R5: index 0D bits 7:0 gate gp10..17
// R6: index 0E bits 7:1 gate peripheral sources
// R7: index 0F reads as all zero
// R8: status sets on event regardless of enables
// R9: write one clears status, zero no effect
// R10: wake is OR of status AND enable, gated by global enable
package wkeg_pkg;
  localparam int ADDR_W = 8;
  localparam int SRC_W = 24;
  localparam int GRP_N = 3;
  localparam logic [SRC_W-1:0] SRC_VALID = 24'h0FFEFF;
  localparam int LANE_GP1X = 0;
  localparam int LANE_PERI = 8;
  localparam int LANE_GP2X = 16;
  localparam int BIT_PORT2_RI = 1;
  localparam int BIT_PORT1_RI = 2;
  localparam int BIT_KEYBOARD = 3;
  localparam int BIT_MOUSE = 4;
  localparam int BIT_SPEC_KEY = 5;
  localparam int BIT_FAN_1 = 6;
  localparam int BIT_FAN_2 = 7;
  localparam logic [5:0] IDX_STS_GP2X = 6'h08;
  localparam logic [5:0] IDX_STS_GP1X = 6'h09;
  localparam logic [5:0] IDX_STS_PERI = 6'h0A;
  localparam logic [5:0] IDX_RSV_0B = 6'h0B;
  localparam logic [5:0] IDX_EN_GP2X = 6'h0C;
  localparam logic [5:0] IDX_EN_GP1X = 6'h0D;
  localparam logic [5:0] IDX_EN_PERI = 6'h0E;
  localparam logic [5:0] IDX_RSV_0F = 6'h0F;
  localparam logic [5:0] IDX_CTRL = 6'h20;
  localparam logic [5:0] IDX_IRQ_STS = 6'h21;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h22;
  localparam logic [SRC_W-1:0] EN_RST = 24'h000000;
  localparam logic [SRC_W-1:0] STS_RST = 24'h000000;
  localparam logic [GRP_N-1:0] IRQ_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/wkeg_top.sv */
// Purpose: wake enable registers, AXI4-Lite slave and open wake output
// Assumes: i_reset is the standby power-on reset; main resets are pins
// Notes: wake pin is open drain, only ever driven low
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module wkeg_top (
  // clock and standby reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // main-supply resets, asynchronous pins
  input wire logic i_main_por,
  input wire logic i_soft_reset,
  input wire logic i_hard_reset,
  // wake sources, asynchronous pins
  input wire logic [7:0] i_gp1x_wake,
  input wire logic [3:0] i_gp2x_wake,
  input wire logic i_port2_ring_indicate,
  input wire logic i_port1_ring_indicate,
  input wire logic i_keyboard_wake,
  input wire logic i_mouse_wake,
  input wire logic i_specific_key_wake,
  input wire logic i_fan_speed_input_1,
  input wire logic i_fan_speed_input_2,
  // axi4-lite write
  input wire logic [wkeg_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [wkeg_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // wake pin and interrupt
  output logic o_wake_output_n_out,
  output logic o_wake_output_n_oe_n,
  output logic o_irq
);
  import wkeg_pkg::*;

  wkeg_gate_if g ();

  logic [SRC_W-1:0] raw_src;
  logic [SRC_W-1:0] src_sync1_ff;
  logic [SRC_W-1:0] src_sync2_ff;
  logic [2:0] rst_sync1_ff;
  logic [2:0] rst_sync2_ff;
  logic main_rst;
  logic [SRC_W-1:0] en_ff;
  logic glob_en_ff;
  logic [GRP_N-1:0] irq_sts_ff;
  logic [GRP_N-1:0] irq_mask_ff;
  logic awready_ff;
  logic aw_hold_ff;
  logic [5:0] aw_idx_ff;
  logic wready_ff;
  logic w_hold_ff;
  logic [7:0] w_byte_ff;
  logic w_lane0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic oe_n_ff;
  logic irq_ff;
  logic wr_go;
  logic wr_en;
  logic ar_fire;
  logic [5:0] ar_idx;
  logic [SRC_W-1:0] nxt_clr;

  // unused peripheral bit 0 and gp2x bits 7:4 stay tied low
  always_comb begin
    raw_src = '0;
    raw_src[LANE_GP1X +: 8] = i_gp1x_wake;
    raw_src[LANE_GP2X +: 4] = i_gp2x_wake;
    raw_src[LANE_PERI + BIT_PORT2_RI] = i_port2_ring_indicate;
    raw_src[LANE_PERI + BIT_PORT1_RI] = i_port1_ring_indicate;
    raw_src[LANE_PERI + BIT_KEYBOARD] = i_keyboard_wake;
    raw_src[LANE_PERI + BIT_MOUSE] = i_mouse_wake;
    raw_src[LANE_PERI + BIT_SPEC_KEY] = i_specific_key_wake;
    raw_src[LANE_PERI + BIT_FAN_1] = i_fan_speed_input_1;
    raw_src[LANE_PERI + BIT_FAN_2] = i_fan_speed_input_2;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      src_sync1_ff <= '0;
      src_sync2_ff <= '0;
    end else begin
      src_sync1_ff <= raw_src;
      src_sync2_ff <= src_sync1_ff;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rst_sync1_ff <= 3'h0;
      rst_sync2_ff <= 3'h0;
    end else begin
      rst_sync1_ff <= {i_main_por, i_soft_reset, i_hard_reset};
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  // main-supply resets only reach the host-facing irq state
  assign main_rst = |rst_sync2_ff;

  assign g.evt = src_sync2_ff;
  assign g.en = en_ff;
  assign g.clr = nxt_clr;
  assign g.glob_en = glob_en_ff;

  wkeg_gate u_gate (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .g(g)
  );

  // write address and data may arrive in either order
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      awready_ff <= 1'b1;
      aw_hold_ff <= 1'b0;
      aw_idx_ff <= 6'h00;
    end else if (i_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      aw_hold_ff <= 1'b1;
      aw_idx_ff <= i_awaddr[7:2];
    end else if (bvalid_ff && i_bready) begin
      awready_ff <= 1'b1;
      aw_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wready_ff <= 1'b1;
      w_hold_ff <= 1'b0;
      w_byte_ff <= 8'h00;
      w_lane0_ff <= 1'b0;
    end else if (i_wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      w_hold_ff <= 1'b1;
      w_byte_ff <= i_wdata[7:0];
      w_lane0_ff <= i_wstrb[0];
    end else if (bvalid_ff && i_bready) begin
      wready_ff <= 1'b1;
      w_hold_ff <= 1'b0;
    end
  end

  assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
  // all fields live in byte lane 0
  assign wr_en = wr_go && w_lane0_ff;

  function automatic logic idx_mapped(input logic [5:0] idx);
    case (idx)
      IDX_STS_GP2X, IDX_STS_GP1X, IDX_STS_PERI, IDX_RSV_0B: idx_mapped = 1'b1;
      IDX_EN_GP2X, IDX_EN_GP1X, IDX_EN_PERI, IDX_RSV_0F: idx_mapped = 1'b1;
      IDX_CTRL, IDX_IRQ_STS, IDX_IRQ_MASK: idx_mapped = 1'b1;
      default: idx_mapped = 1'b0;
    endcase
  endfunction

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= idx_mapped(aw_idx_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && i_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // write-one-to-clear pulses into the status latch
  always_comb begin
    nxt_clr = '0;
    if (wr_en) begin
      case (aw_idx_ff)
        IDX_STS_GP1X: nxt_clr[LANE_GP1X +: 8] = w_byte_ff; // [R9]
        IDX_STS_PERI: nxt_clr[LANE_PERI +: 8] = w_byte_ff; // [R9]
        IDX_STS_GP2X: nxt_clr[LANE_GP2X +: 8] = w_byte_ff; // [R9]
        default: nxt_clr = '0;
      endcase
    end
  end

  // only standby reset clears the enables
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      en_ff <= EN_RST; // [R3]
    end else if (wr_en) begin
      case (aw_idx_ff)
        IDX_EN_GP2X: en_ff[LANE_GP2X +: 8] <= w_byte_ff & SRC_VALID[LANE_GP2X +: 8]; // [R4]
        IDX_EN_GP1X: en_ff[LANE_GP1X +: 8] <= w_byte_ff; // [R5]
        IDX_EN_PERI: en_ff[LANE_PERI +: 8] <= w_byte_ff & SRC_VALID[LANE_PERI +: 8]; // [R6]
        default: en_ff <= en_ff;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      glob_en_ff <= 1'b0;
    end else if (wr_en && aw_idx_ff == IDX_CTRL) begin
      glob_en_ff <= w_byte_ff[0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset || main_rst) begin
      irq_mask_ff <= IRQ_RST;
    end else if (wr_en && aw_idx_ff == IDX_IRQ_MASK) begin
      irq_mask_ff <= w_byte_ff[GRP_N-1:0];
    end
  end

  assign ar_fire = i_arvalid && arready_ff;
  assign ar_idx = i_araddr[7:2];

  // read clears, but a new event in the same cycle survives
  always_ff @(posedge i_core_clk) begin
    if (i_reset || main_rst) begin
      irq_sts_ff <= IRQ_RST;
    end else if (ar_fire && ar_idx == IDX_IRQ_STS) begin
      irq_sts_ff <= g.new_set;
    end else begin
      irq_sts_ff <= irq_sts_ff | g.new_set;
    end
  end

  function automatic logic [31:0] rd_word(input logic [5:0] idx);
    rd_word = 32'h00000000;
    case (idx)
      IDX_STS_GP1X: rd_word[7:0] = g.sts[LANE_GP1X +: 8];
      IDX_STS_PERI: rd_word[7:0] = g.sts[LANE_PERI +: 8];
      IDX_STS_GP2X: rd_word[7:0] = g.sts[LANE_GP2X +: 8];
      IDX_EN_GP2X: rd_word[7:0] = en_ff[LANE_GP2X +: 8];
      IDX_EN_GP1X: rd_word[7:0] = en_ff[LANE_GP1X +: 8];
      IDX_EN_PERI: rd_word[7:0] = en_ff[LANE_PERI +: 8];
      IDX_CTRL: rd_word[0] = glob_en_ff;
      IDX_IRQ_STS: rd_word[GRP_N-1:0] = irq_sts_ff;
      IDX_IRQ_MASK: rd_word[GRP_N-1:0] = irq_mask_ff;
      default: rd_word = 32'h00000000; // [R7]
    endcase
  endfunction

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (ar_fire) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word(ar_idx); // [R4] [R5] [R6] [R7]
      rresp_ff <= idx_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && i_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  // open drain: enable low pulls the wire low
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      oe_n_ff <= 1'b1;
      irq_ff <= 1'b0;
    end else begin
      oe_n_ff <= ~g.wake; // [R1] [R10]
      irq_ff <= |(irq_sts_ff & irq_mask_ff);
    end
  end

  assign o_awready = awready_ff;
  assign o_wready = wready_ff;
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;
  assign o_arready = arready_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;
  assign o_wake_output_n_out = 1'b0;
  assign o_wake_output_n_oe_n = oe_n_ff;
  assign o_irq = irq_ff;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  a_wake_from_enabled: assert property ( // [R1]
    (glob_en_ff && (en_ff & g.sts) != '0) |=> !o_wake_output_n_oe_n
  ) else $error("enabled latched source did not drive wake");

  a_disabled_no_wake: assert property ( // [R2]
    ((en_ff & g.sts) == '0) |=> o_wake_output_n_oe_n
  ) else $error("wake driven with no enabled latched source");

  a_en_hold_reset: assert property ( // [R3]
    (main_rst && !wr_en) |=> $stable(en_ff)
  ) else $error("main reset disturbed enables");

  a_gp2x_read_map: assert property ( // [R4]
    (ar_fire && ar_idx == IDX_EN_GP2X) |=>
      (o_rdata[31:4] == 28'h0000000 && o_rdata[3:0] == $past(en_ff[19:16]))
  ) else $error("gp2x enable read wrong");

  a_gp1x_read_map: assert property ( // [R5]
    (ar_fire && ar_idx == IDX_EN_GP1X) |=> o_rdata[7:0] == $past(en_ff[7:0])
  ) else $error("gp1x enable read wrong");

  a_peri_read_map: assert property ( // [R6]
    (ar_fire && ar_idx == IDX_EN_PERI) |=>
      (o_rdata[0] == 1'b0 && o_rdata[7:1] == $past(en_ff[15:9]))
  ) else $error("peripheral enable read wrong");

  a_hole_reads_zero: assert property ( // [R7]
    (ar_fire && ar_idx == IDX_RSV_0F) |=> (o_rdata == 32'h00000000 && o_rresp == RESP_OKAY)
  ) else $error("reserved word not zero");

  a_status_sets: assert property ( // [R8]
    ((g.evt & SRC_VALID) != '0) |=>
      ((g.sts & $past(g.evt) & SRC_VALID) == ($past(g.evt) & SRC_VALID))
  ) else $error("wake event not latched");

  a_w1c_clears: assert property ( // [R9]
    (g.clr != '0 && (g.evt & g.clr) == '0) |=> (g.sts & $past(g.clr)) == '0
  ) else $error("write one did not clear status");

  a_wake_release: assert property ( // [R10]
    !glob_en_ff [*2] |-> o_wake_output_n_oe_n
  ) else $error("wake held without global enable");

  c_wake_asserted: cover property (!o_wake_output_n_oe_n ##1 o_wake_output_n_oe_n);
  c_irq_read_clear: cover property (o_irq ##[1:20] (ar_fire && ar_idx == IDX_IRQ_STS));
  c_slverr_write: cover property (o_bvalid && o_bresp == RESP_SLVERR);
endmodule

/* File: tb/tb_wake_event_enable_gating.sv */
// Purpose: self-checking bench for the wake enable gating block
// Assumes: register byte address is index * 4
// Notes: random enables from a fixed seed, corner cases by hand
`timescale 1ns/1ps
module tb_wake_event_enable_gating;
  import wkeg_pkg::*;
  logic clk = 1'b0, rst = 1'b1, mpor = 1'b0, srst = 1'b0, hrst = 1'b0;
  logic [23:0] src = 24'h000000;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rd;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, wk_out, wk_oe_n, irq, seen;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  integer fails = 0, tests_run = 0, seed = 32'h7179f12e, s, g, b;
  logic en_on;
  always #5 clk = ~clk;
  wkeg_top dut_u (.i_core_clk(clk), .i_reset(rst), .i_main_por(mpor), .i_soft_reset(srst),
    .i_hard_reset(hrst), .i_gp1x_wake(src[7:0]), .i_gp2x_wake(src[19:16]),
    .i_port2_ring_indicate(src[9]), .i_port1_ring_indicate(src[10]),
    .i_keyboard_wake(src[11]), .i_mouse_wake(src[12]), .i_specific_key_wake(src[13]),
    .i_fan_speed_input_1(src[14]), .i_fan_speed_input_2(src[15]),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_wake_output_n_out(wk_out), .o_wake_output_n_oe_n(wk_oe_n),
    .o_irq(irq));
  wkeg_chipset_model chip_u (.i_core_clk(clk), .i_wake_out(wk_out), .i_wake_oe_n(wk_oe_n),
    .o_wake_seen(seen));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task print_verdict;
    $display("checks=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
      if (++n > 1000) begin
        fails++;
        break;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
      if (++n > 1000) begin
        fails++;
        break;
      end
    end
  endtask

  // group 0 gp1x, 1 peripherals, 2 gp2x; status sits 0x10 below enable
  function automatic logic [7:0] en_addr(input int grp);
    return (grp == 0) ? 8'h34 : (grp == 1) ? 8'h38 : 8'h30;
  endfunction

  function automatic logic [7:0] grp_mask(input int grp);
    return SRC_VALID[grp*8 +: 8];
  endfunction

  initial begin
    #500000;
    fails++;
    print_verdict;
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (g = 0; g < 3; g++) begin
      axr(en_addr(g));
      check(rd, 32'h0);
    end
    axr(8'h3C);
    check(rd, 32'h0);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    axr(8'h2C);
    check(rd, 32'h0);
    axr(8'hF0);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    for (g = 0; g < 3; g++) begin
      b = $random(seed);
      axw(en_addr(g), b, 4'hF);
      axr(en_addr(g));
      check(rd, {24'h0, b[7:0] & grp_mask(g)});
    end
    axw(8'h3C, $random(seed) | 32'hFF, 4'hF);
    axr(8'h3C);
    check(rd, 32'h0);
    // lane 0 strobe off: write must be dropped
    axr(8'h34);
    b = rd;
    axw(8'h34, ~b, 4'hE);
    axr(8'h34);
    check(rd, b);
    axw(8'hF0, 32'hFF, 4'hF);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    axw(8'h80, 32'h1, 4'hF);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    for (s = 0; s < 24; s++) begin
      if (SRC_VALID[s]) begin
        g = s / 8;
        en_on = $random(seed);
        axw(en_addr(g), en_on ? (32'h1 << (s % 8)) : 32'h0, 4'hF);
        src[s] <= 1'b1;
        repeat (8) @(posedge clk);
        axr(en_addr(g) - 8'h10);
        check(rd, 32'h1 << (s % 8));
        check({31'h0, seen}, {31'h0, en_on});
        src[s] <= 1'b0;
        repeat (4) @(posedge clk);
        axw(en_addr(g) - 8'h10, 32'h0, 4'hF);
        axr(en_addr(g) - 8'h10);
        check(rd, 32'h1 << (s % 8));
        axw(en_addr(g) - 8'h10, 32'h1 << (s % 8), 4'hF);
        repeat (4) @(posedge clk);
        axr(en_addr(g) - 8'h10);
        check(rd, 32'h0);
        check({31'h0, seen}, 32'h0);
      end
    end
    // global enable low blocks an enabled, latched source
    axw(8'h80, 32'h0, 4'hF);
    axw(8'h34, 32'h1, 4'hF);
    // every group latched new events in the sweep; read them away first
    axr(8'h84);
    check(rd, 32'h7);
    axw(8'h88, 32'h1, 4'hF);
    src[0] <= 1'b1;
    repeat (8) @(posedge clk);
    check({31'h0, seen}, 32'h0);
    check({31'h0, irq}, 32'h1);
    axr(8'h84);
    check(rd, 32'h1);
    src[0] <= 1'b0;
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    axw(8'h80, 32'h1, 4'hF);
    repeat (4) @(posedge clk);
    check({31'h0, seen}, 32'h1);
    // main-supply resets leave enables, status and wake untouched
    mpor <= 1'b1;
    srst <= 1'b1;
    hrst <= 1'b1;
    repeat (4) @(posedge clk);
    mpor <= 1'b0;
    srst <= 1'b0;
    hrst <= 1'b0;
    repeat (4) @(posedge clk);
    axr(8'h34);
    check(rd, 32'h1);
    axr(8'h24);
    check(rd, 32'h1);
    check({31'h0, seen}, 32'h1);
    axr(8'h88);
    check(rd, 32'h0);
    // masked group: event must not raise the interrupt
    src[1] <= 1'b1;
    repeat (8) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    src[1] <= 1'b0;
    // standby reset is the only one that clears the enables
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    axr(8'h34);
    check(rd, 32'h0);
    axr(8'h24);
    check(rd, 32'h0);
    repeat (3) @(posedge clk);
    check({31'h0, seen}, 32'h0);
    print_verdict;
  end
endmodule

/* File: tb/wkeg_chipset_model.sv */
// Purpose: chipset side of the wake wire, pull-up plus input sync
// Assumes: wire is open drain with a pull-up at the chipset
// Notes: o_wake_seen lags the wire by two edges
`timescale 1ns/1ps
module wkeg_chipset_model (
  // clock
  input wire logic i_core_clk,
  // wake wire from the device
  input wire logic i_wake_out,
  input wire logic i_wake_oe_n,
  // decoded wake request
  output logic o_wake_seen
);
  logic wire_lvl;
  logic sync_ff;
  // released wire floats to the pull-up level, never the last driven value
  assign wire_lvl = i_wake_oe_n ? 1'b1 : i_wake_out;
  always_ff @(posedge i_core_clk) begin
    sync_ff <= ~wire_lvl;
    o_wake_seen <= sync_ff;
  end
endmodule
